// File: pwm_timer16_pkg.sv
package pwm_timer16_pkg;

  // register offsets (word index on the plain register port)
  localparam logic [3:0] OFF_CTRL      = 4'h0;
  localparam logic [3:0] OFF_PRESCALE  = 4'h1;
  localparam logic [3:0] OFF_COUNT     = 4'h2;
  localparam logic [3:0] OFF_CMP_A     = 4'h3;
  localparam logic [3:0] OFF_CMP_B     = 4'h4;
  localparam logic [3:0] OFF_CAPTURE   = 4'h5;
  localparam logic [3:0] OFF_FLAGS     = 4'h6;
  localparam logic [3:0] OFF_DIR       = 4'h7;

  // control register fields
  localparam int CTRL_WGM_LSB    = 0;
  localparam int CTRL_ACT_A_LSB  = 4;
  localparam int CTRL_ACT_B_LSB  = 6;
  localparam logic [15:0] CTRL_RESET = 16'h0000;

  // flag register bit positions, write one to clear
  localparam int FLAG_OVF     = 0;
  localparam int FLAG_CMP_A   = 1;
  localparam int FLAG_CMP_B   = 2;
  localparam int FLAG_CAPTURE = 3;

  // waveform select codes handled here
  localparam logic [3:0] WGM_PC8     = 4'h1;
  localparam logic [3:0] WGM_PC9     = 4'h2;
  localparam logic [3:0] WGM_PC10    = 4'h3;
  localparam logic [3:0] WGM_PFC_CAP = 4'h8;
  localparam logic [3:0] WGM_PFC_A   = 4'h9;
  localparam logic [3:0] WGM_PC_CAP  = 4'ha;
  localparam logic [3:0] WGM_PC_A    = 4'hb;

  localparam logic [15:0] TOP_8BIT  = 16'h00ff;
  localparam logic [15:0] TOP_9BIT  = 16'h01ff;
  localparam logic [15:0] TOP_10BIT = 16'h03ff;

  // output action select codes
  localparam logic [1:0] ACT_OFF    = 2'h0;
  localparam logic [1:0] ACT_TOGGLE = 2'h1;
  localparam logic [1:0] ACT_NONINV = 2'h2;
  localparam logic [1:0] ACT_INV    = 2'h3;

  // prescaler select: divide by 1, 8, 64, 256, 1024; 0 stops the timer
  localparam logic [2:0] PRE_STOP = 3'h0;
  localparam logic [2:0] PRE_1    = 3'h1;
  localparam logic [2:0] PRE_8    = 3'h2;
  localparam logic [2:0] PRE_64   = 3'h3;
  localparam logic [2:0] PRE_256  = 3'h4;
  localparam logic [2:0] PRE_1024 = 3'h5;

  typedef struct packed {
    logic [3:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } reg_req_t;

  typedef enum logic {DIR_UP, DIR_DOWN} count_dir_t;

endpackage : pwm_timer16_pkg

// File: dual_slope_pwm_timer16.sv
// The register addresses and the strobed register port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module dual_slope_pwm_timer16 #(
  parameter int WIDTH = 16
) (
  // clock and reset
  input  wire logic                     clk,
  input  wire logic                     arst_n,
  input  wire logic                     clk_en,
  // register port
  input  wire pwm_timer16_pkg::reg_req_t req,
  output logic      [15:0]              rdata,
  // port function that the pins fall back to
  input  wire logic [1:0]               port_data,
  // pins
  output logic [1:0]                    pin_out,
  output logic [1:0]                    pin_oe
);

  if (WIDTH != 16) begin : g_width_check
    $error("only a 16-bit timer is supported");
  end

  logic [15:0] ctrl_r;
  logic [2:0]  prescale_r;
  logic [9:0]  pre_cnt_r;
  logic [15:0] timer_count_value;
  pwm_timer16_pkg::count_dir_t dir_r;
  logic [15:0] cmp_buf_r [2];
  logic [15:0] cmp_act_r [2];
  logic [15:0] capture_top_register;
  logic [3:0]  flags_r;
  logic [1:0]  pin_direction_bit;
  logic [1:0]  waveform_output;
  logic        timer_tick;
  logic [3:0]  waveform_select;
  logic [15:0] top;
  logic        fixed_top;
  logic        pfc_mode;
  logic        pc_mode;
  logic        at_top;
  logic        at_zero;
  logic        reload;
  logic [15:0] top_mask;
  logic        wave_hi;
  logic [3:0]  flag_set;
  logic [3:0]  flag_clr;

  assign waveform_select = ctrl_r[pwm_timer16_pkg::CTRL_WGM_LSB +: 4];

  // action select of a channel
  function automatic logic [1:0] act_of(input logic [15:0] c,
                                        input int ch);
    act_of = (ch == 0) ? c[pwm_timer16_pkg::CTRL_ACT_A_LSB +: 2]
                       : c[pwm_timer16_pkg::CTRL_ACT_B_LSB +: 2];
  endfunction : act_of

  always_comb begin
    pc_mode   = 1'b0;
    pfc_mode  = 1'b0;
    fixed_top = 1'b0;
    top       = 16'hffff;
    unique case (waveform_select)
      pwm_timer16_pkg::WGM_PC8: begin
        pc_mode   = 1'b1;
        fixed_top = 1'b1;
        top       = pwm_timer16_pkg::TOP_8BIT;
      end
      pwm_timer16_pkg::WGM_PC9: begin
        pc_mode   = 1'b1;
        fixed_top = 1'b1;
        top       = pwm_timer16_pkg::TOP_9BIT;
      end
      pwm_timer16_pkg::WGM_PC10: begin
        pc_mode   = 1'b1;
        fixed_top = 1'b1;
        top       = pwm_timer16_pkg::TOP_10BIT;
      end
      pwm_timer16_pkg::WGM_PC_CAP: begin
        pc_mode = 1'b1;
        top     = capture_top_register;
      end
      pwm_timer16_pkg::WGM_PC_A: begin
        pc_mode = 1'b1;
        top     = cmp_act_r[0];
      end
      pwm_timer16_pkg::WGM_PFC_CAP: begin
        pfc_mode = 1'b1;
        top      = capture_top_register;
      end
      pwm_timer16_pkg::WGM_PFC_A: begin
        pfc_mode = 1'b1;
        top      = cmp_act_r[0];
      end
      default: begin
        top = 16'hffff;
      end
    endcase
  end

  assign top_mask = fixed_top ? top : 16'hffff;
  assign at_top   = (timer_count_value == top);
  assign at_zero  = (timer_count_value == 16'h0000);
  // level a non-inverted match leaves: TOP counts as high, zero as low,
  // otherwise a compare of zero would latch high at the bottom turn
  assign wave_hi  = ((dir_r == pwm_timer16_pkg::DIR_DOWN) || at_top) &&
                    !at_zero;
  // reload point differs per mode
  assign reload   = timer_tick &&
                    ((pc_mode && at_top) || (pfc_mode && at_zero));

  // prescaler: tick is a clock enable only, never a clock
  always_comb begin
    unique case (prescale_r)
      pwm_timer16_pkg::PRE_1:    timer_tick = 1'b1;
      pwm_timer16_pkg::PRE_8:    timer_tick = (pre_cnt_r[2:0] == 3'h7);
      pwm_timer16_pkg::PRE_64:   timer_tick = (pre_cnt_r[5:0] == 6'h3f);
      pwm_timer16_pkg::PRE_256:  timer_tick = (pre_cnt_r[7:0] == 8'hff);
      pwm_timer16_pkg::PRE_1024: timer_tick = (pre_cnt_r == 10'h3ff);
      default:                   timer_tick = 1'b0;
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pre_cnt_r <= 10'h000;
    end else if (clk_en) begin
      if (prescale_r == pwm_timer16_pkg::PRE_STOP) begin
        pre_cnt_r <= 10'h000;
      end else begin
        pre_cnt_r <= pre_cnt_r + 10'h001;
      end
    end
  end

  // counter and direction
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      timer_count_value <= 16'h0000;
      dir_r             <= pwm_timer16_pkg::DIR_UP;
    end else if (clk_en) begin
      if (req.wr && req.addr == pwm_timer16_pkg::OFF_COUNT) begin
        timer_count_value <= req.wdata;
      end else if (timer_tick && (pc_mode || pfc_mode)) begin
        if (dir_r == pwm_timer16_pkg::DIR_UP) begin
          if (at_top) begin
            // direction turns at top and the count falls on this same tick
            dir_r             <= pwm_timer16_pkg::DIR_DOWN;
            timer_count_value <= timer_count_value - 16'h0001;
          end else begin
            timer_count_value <= timer_count_value + 16'h0001;
          end
        end else begin
          if (at_zero) begin
            dir_r             <= pwm_timer16_pkg::DIR_UP;
            timer_count_value <= timer_count_value + 16'h0001;
          end else begin
            timer_count_value <= timer_count_value - 16'h0001;
          end
        end
      end
    end
  end

  // compare buffers and active compares
  for (genvar ch = 0; ch < 2; ch++) begin : g_cmp
    localparam logic [3:0] OFF = (ch == 0) ? pwm_timer16_pkg::OFF_CMP_A
                                           : pwm_timer16_pkg::OFF_CMP_B;
    always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
        cmp_buf_r[ch] <= 16'h0000;
      end else if (clk_en && req.wr && req.addr == OFF) begin
        cmp_buf_r[ch] <= req.wdata & top_mask;
      end
    end
    always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
        cmp_act_r[ch] <= 16'h0000;
      end else if (clk_en && reload) begin
        cmp_act_r[ch] <= cmp_buf_r[ch];
      end
    end

    // waveform: clear on up match, set on down match for non-inverted
    always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
        waveform_output[ch] <= 1'b0;
      end else if (clk_en && timer_tick && (pc_mode || pfc_mode) &&
                   timer_count_value == cmp_act_r[ch]) begin
        unique case (act_of(ctrl_r, ch))
          pwm_timer16_pkg::ACT_NONINV:
            // at TOP the up match holds high, so compare==TOP stays high
            waveform_output[ch] <= wave_hi;
          pwm_timer16_pkg::ACT_INV:
            waveform_output[ch] <= !wave_hi;
          pwm_timer16_pkg::ACT_TOGGLE:
            if (ch == 0 && (waveform_select == pwm_timer16_pkg::WGM_PC_A ||
                            waveform_select == pwm_timer16_pkg::WGM_PFC_A))
              waveform_output[ch] <= !waveform_output[ch];
          default: ;
        endcase
      end
    end

    // pin mux: disconnected action keeps port function; the direction bit only sets the enable
    always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
        pin_out[ch] <= 1'b0;
        pin_oe[ch]  <= 1'b0;
      end else if (clk_en) begin
        pin_oe[ch]  <= pin_direction_bit[ch];
        pin_out[ch] <= (act_of(ctrl_r, ch) == pwm_timer16_pkg::ACT_OFF)
                       ? port_data[ch] : waveform_output[ch];
      end
    end
  end

  // flags: hardware set wins over a clear in the same cycle
  always_comb begin
    flag_set = 4'h0;
    flag_clr = 4'h0;
    if (req.wr && req.addr == pwm_timer16_pkg::OFF_FLAGS) begin
      flag_clr = req.wdata[3:0];
    end
    if (timer_tick && (pc_mode || pfc_mode)) begin
      if (pc_mode && at_zero) begin
        flag_set[pwm_timer16_pkg::FLAG_OVF] = 1'b1;
      end
      if (reload && pfc_mode) begin
        flag_set[pwm_timer16_pkg::FLAG_OVF] = 1'b1;
      end
      if (timer_count_value == cmp_act_r[0]) begin
        flag_set[pwm_timer16_pkg::FLAG_CMP_A] = 1'b1;
      end
      if (timer_count_value == cmp_act_r[1]) begin
        flag_set[pwm_timer16_pkg::FLAG_CMP_B] = 1'b1;
      end
      if (at_top) begin
        // pc sets these with the reload at TOP; pfc sets at TOP too
        if (waveform_select == pwm_timer16_pkg::WGM_PC_A ||
            waveform_select == pwm_timer16_pkg::WGM_PFC_A) begin
          flag_set[pwm_timer16_pkg::FLAG_CMP_A] = 1'b1;
        end
        if (waveform_select == pwm_timer16_pkg::WGM_PC_CAP ||
            waveform_select == pwm_timer16_pkg::WGM_PFC_CAP) begin
          flag_set[pwm_timer16_pkg::FLAG_CAPTURE] = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      flags_r <= 4'h0;
    end else if (clk_en) begin
      flags_r <= (flags_r & ~flag_clr) | flag_set;
    end
  end

  // plain software registers
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_r               <= pwm_timer16_pkg::CTRL_RESET;
      prescale_r           <= pwm_timer16_pkg::PRE_STOP;
      capture_top_register <= 16'h0000;
      pin_direction_bit    <= 2'h0;
    end else if (clk_en && req.wr) begin
      unique case (req.addr)
        pwm_timer16_pkg::OFF_CTRL:     ctrl_r <= req.wdata;
        pwm_timer16_pkg::OFF_PRESCALE: prescale_r <= req.wdata[2:0];
        pwm_timer16_pkg::OFF_CAPTURE:  capture_top_register <= req.wdata;
        pwm_timer16_pkg::OFF_DIR:      pin_direction_bit <= req.wdata[1:0];
        default: ;
      endcase
    end
  end

  // read data one cycle after the strobe, zero otherwise
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata <= 16'h0000;
    end else if (clk_en) begin
      rdata <= 16'h0000;
      if (req.rd) begin
        unique case (req.addr)
          pwm_timer16_pkg::OFF_CTRL:     rdata <= ctrl_r;
          pwm_timer16_pkg::OFF_PRESCALE: rdata <= {13'h0000, prescale_r};
          pwm_timer16_pkg::OFF_COUNT:    rdata <= timer_count_value;
          pwm_timer16_pkg::OFF_CMP_A:    rdata <= cmp_buf_r[0];
          pwm_timer16_pkg::OFF_CMP_B:    rdata <= cmp_buf_r[1];
          pwm_timer16_pkg::OFF_CAPTURE:  rdata <= capture_top_register;
          pwm_timer16_pkg::OFF_FLAGS:    rdata <= {12'h000, flags_r};
          pwm_timer16_pkg::OFF_DIR:      rdata <= {14'h0000, pin_direction_bit};
          default:                       rdata <= 16'h0000;
        endcase
      end
    end
  end

endmodule : dual_slope_pwm_timer16
`default_nettype wire

// File: pwm_timer16_checker.sv
`timescale 1ns/1ps
`default_nettype none

module pwm_timer16_checker #(
  parameter int WIDTH = 16
) (
  // clock and reset
  input  wire logic                      clk,
  input  wire logic                      arst_n,
  input  wire logic                      clk_en,
  // register port
  input  wire pwm_timer16_pkg::reg_req_t req,
  input  wire logic [15:0]               rdata,
  // pins
  input  wire logic [1:0]                port_data,
  input  wire logic [1:0]                pin_out,
  input  wire logic [1:0]                pin_oe
);
  logic [15:0] ctrl_r;
  logic [15:0] cmpa_r;
  logic [15:0] cmpb_r;
  logic [15:0] msk;
  logic [15:0] cmp_sel;
  logic        rd_go;
  logic        dir_wr;
  logic [1:0]  pin_dir_r;

  assign rd_go = clk_en && req.rd;
  assign dir_wr = clk_en && req.wr && req.addr == pwm_timer16_pkg::OFF_DIR;
  assign cmp_sel = (req.addr == pwm_timer16_pkg::OFF_CMP_A) ? cmpa_r : cmpb_r;

  // all ones outside the fixed-top modes, so no masking there
  always_comb begin
    case (ctrl_r[3:0])
      pwm_timer16_pkg::WGM_PC8:  msk = pwm_timer16_pkg::TOP_8BIT;
      pwm_timer16_pkg::WGM_PC9:  msk = pwm_timer16_pkg::TOP_9BIT;
      pwm_timer16_pkg::WGM_PC10: msk = pwm_timer16_pkg::TOP_10BIT;
      default:                   msk = 16'hffff;
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_r <= 16'h0000;
      cmpa_r <= 16'h0000;
      cmpb_r <= 16'h0000;
      pin_dir_r <= 2'h0;
    end else if (clk_en && req.wr) begin
      if (req.addr == pwm_timer16_pkg::OFF_CTRL)
        ctrl_r <= req.wdata;
      if (req.addr == pwm_timer16_pkg::OFF_CMP_A)
        cmpa_r <= req.wdata & msk;
      if (req.addr == pwm_timer16_pkg::OFF_CMP_B)
        cmpb_r <= req.wdata & msk;
      if (req.addr == pwm_timer16_pkg::OFF_DIR)
        pin_dir_r <= req.wdata[1:0];
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  rdata_idle_a: assert property (clk_en && !req.rd |=> rdata == 16'h0000)
    else $error("read data not zero outside a read answer");
  unmapped_read_a: assert property (rd_go
    && req.addr > pwm_timer16_pkg::OFF_DIR |=> rdata == 16'h0000)
    else $error("unmapped read returned data");
  tick_freeze_a: assert property (
    !clk_en |=> $stable(pin_out) && $stable(pin_oe) && $stable(rdata))
    else $error("state moved while the clock enable was low");
  // the pin enable is a registered copy of the direction register
  dir_load_a: assert property (
    dir_wr ##1 clk_en |=> pin_oe == $past(req.wdata[1:0], 2))
    else $error("pin enable does not follow direction write");
  dir_hold_a: assert property (
    clk_en |=> pin_oe == $past(pin_dir_r))
    else $error("pin enable differs from the direction register");
  port_fall_a: assert property (
    clk_en && ctrl_r[5:4] == 2'h0 |=> pin_out[0] == $past(port_data[0]))
    else $error("pin a left its port function while disconnected");
  port_fall_b_a: assert property (
    clk_en && ctrl_r[7:6] == 2'h0 |=> pin_out[1] == $past(port_data[1]))
    else $error("pin b left its port function while disconnected");
  cmp_mask_a: assert property (rd_go && (req.addr == 4'h3
    || req.addr == 4'h4) |=> rdata == $past(cmp_sel))
    else $error("compare readback differs from masked write");
  count_top_a: assert property (rd_go && msk != 16'hffff
    && req.addr == pwm_timer16_pkg::OFF_COUNT |=> rdata <= $past(msk))
    else $error("counter read above the fixed top");
endmodule : pwm_timer16_checker

bind dual_slope_pwm_timer16 pwm_timer16_checker #(.WIDTH(WIDTH)) chk_inst (
  .clk(clk), .arst_n(arst_n), .clk_en(clk_en), .req(req), .rdata(rdata),
  .port_data(port_data), .pin_out(pin_out), .pin_oe(pin_oe));

`default_nettype wire

// File: pwm_load_model.sv
`timescale 1ns/1ps
`default_nettype none

module pwm_load_model (
  // pins of the timer
  input  wire logic [1:0] pin_out,
  input  wire logic [1:0] pin_oe,
  // level the load sees
  output logic      [1:0] level
);
  // an undriven pin is held high by the load's pull-up
  assign level = (pin_out & pin_oe) | ~pin_oe;
endmodule : pwm_load_model

`default_nettype wire

// File: tb.sv
`timescale 1ns/1ps
`default_nettype none

module tb;
  logic                      clk = 1'b0;
  logic                      arst_n = 1'b0;
  logic                      clk_en = 1'b1;
  logic [1:0]                port_data = 2'h0;
  pwm_timer16_pkg::reg_req_t req = '0;
  logic [15:0]               rdata;
  logic [1:0]                pin_out;
  logic [1:0]                pin_oe;
  logic [1:0]                level;
  int                        miscompares = 0;
  int                        samples_checked = 0;
  int                        cycles = 0;
  int                        modes [10] = '{1, 2, 3, 8, 9, 10, 11, 10, 8, 11};
  int                        pres [10] = '{1, 1, 1, 2, 3, 1, 1, 4, 5, 1};
  int                        divs [5] = '{1, 8, 64, 256, 1024};

  dual_slope_pwm_timer16 #(.WIDTH(16)) dual_slope_pwm_timer16_inst (
    .clk(clk), .arst_n(arst_n), .clk_en(clk_en), .req(req), .rdata(rdata),
    .port_data(port_data), .pin_out(pin_out), .pin_oe(pin_oe));
  pwm_load_model pwm_load_model_inst (
    .pin_out(pin_out), .pin_oe(pin_oe), .level(level));

  always #5 clk = ~clk;

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : report_and_stop

  always @(posedge clk) begin
    cycles++;
    if (cycles == 90000) begin
      miscompares++;
      report_and_stop();
    end
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk) req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk) req <= '0;
  endtask : wr

  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk) req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge clk) req <= '0;
    @(negedge clk) d = rdata;
  endtask : rd

  // high cycles over two output periods of 2*top ticks each
  function automatic logic [15:0] highs(input logic [1:0] act,
                                        input int cmp, top, dv,
                                        input logic pd);
    case (act)
      pwm_timer16_pkg::ACT_NONINV: return 16'(4 * cmp * dv);
      pwm_timer16_pkg::ACT_INV:    return 16'(4 * (top - cmp) * dv);
      pwm_timer16_pkg::ACT_TOGGLE: return 16'(2 * top * dv);
      default:                     return pd ? 16'(4 * top * dv) : 16'h0;
    endcase
  endfunction : highs

  initial begin : main
    logic [15:0] d, ha, hb, top, ca, cb, w;
    logic [1:0]  aa, ab, dir, pd;
    logic        amode;
    int          dv;
    void'($urandom(39));
    repeat (20) @(posedge clk);
    arst_n <= 1'b1;
    rd(4'hf, d);
    check(d, 16'h0000);
    for (int i = 0; i < 10; i++) begin
      dv = divs[pres[i] - 1];
      amode = modes[i] == 9 || modes[i] == 11;
      case (modes[i])
        1:       top = pwm_timer16_pkg::TOP_8BIT;
        2:       top = pwm_timer16_pkg::TOP_9BIT;
        3:       top = pwm_timer16_pkg::TOP_10BIT;
        default: begin
          top = 16'(3 + $urandom % (pres[i] > 2 ? 2 : 40));
        end
      endcase
      w = 16'($urandom);
      ca = modes[i] < 4 ? w & top : amode ? top : w % (top + 16'h1);
      cb = i == 0 ? 16'h0 : i == 1 ? top
                  : 16'($urandom % (top + 1));
      aa = i[1] ? pwm_timer16_pkg::ACT_NONINV : pwm_timer16_pkg::ACT_INV;
      if (amode && i < 9)
        aa = pwm_timer16_pkg::ACT_TOGGLE;
      if (i == 7)
        aa = pwm_timer16_pkg::ACT_OFF;
      ab = i[0] ? pwm_timer16_pkg::ACT_INV : pwm_timer16_pkg::ACT_NONINV;
      dir = i == 8 ? 2'b01 : 2'b11;
      pd = 2'($urandom);
      // counter stopped while the mode changes so no read sees a stale top
      wr(pwm_timer16_pkg::OFF_PRESCALE, 16'h0);
      wr(pwm_timer16_pkg::OFF_CTRL, {8'h00, ab, aa, 4'(modes[i])});
      wr(pwm_timer16_pkg::OFF_CAPTURE, top);
      wr(pwm_timer16_pkg::OFF_CMP_A, modes[i] < 4 ? w : ca);
      wr(pwm_timer16_pkg::OFF_CMP_B, cb);
      // two ticks from zero in a capture-top mode load the new compares,
      // so a stale channel A top cannot carry the count past the new top
      wr(pwm_timer16_pkg::OFF_CTRL, {12'h000, pwm_timer16_pkg::WGM_PFC_CAP});
      wr(pwm_timer16_pkg::OFF_PRESCALE, 16'h0001);
      wr(pwm_timer16_pkg::OFF_PRESCALE, 16'h0);
      wr(pwm_timer16_pkg::OFF_CTRL, {8'h00, ab, aa, 4'(modes[i])});
      wr(pwm_timer16_pkg::OFF_COUNT, 16'h0);
      wr(pwm_timer16_pkg::OFF_FLAGS, 16'h000f);
      wr(pwm_timer16_pkg::OFF_DIR, {14'h0, dir});
      port_data <= pd;
      wr(pwm_timer16_pkg::OFF_PRESCALE, 16'(pres[i]));
      rd(pwm_timer16_pkg::OFF_CMP_A, d);
      check(d, ca);
      repeat (4 * top * dv) @(posedge clk);
      ha = 16'h0;
      hb = 16'h0;
      repeat (4 * top * dv) @(negedge clk) begin
        ha += level[0];
        hb += level[1];
      end
      check(ha, highs(aa, ca, top, dv, pd[0]));
      // an input pin leaves the load's pull-up in charge of the level
      check(hb, highs(dir[1] ? ab : pwm_timer16_pkg::ACT_OFF, cb, top, dv,
                      pd[1] | ~dir[1]));
      rd(pwm_timer16_pkg::OFF_FLAGS, d);
      check(16'(d[3:0]), {12'h0, modes[i] == 8 || modes[i] == 10, 3'h7});
      rd(pwm_timer16_pkg::OFF_COUNT, d);
      check(16'(d <= top), 16'h0001);
      @(posedge clk) clk_en <= 1'b0;
      repeat (20) @(posedge clk);
      clk_en <= 1'b1;
      $display("test %0d done", i);
    end
    report_and_stop();
  end
endmodule : tb

`default_nettype wire
